/* logic/dsbr_top.sv */
// dual sink brightness control: mode decode, registers and ramp channels
`timescale 1ns/1ps
module dsbr_top
    import dsbr_pkg::*;
#(
    parameter int unsigned DWELL_00 = DWELL_00_CYC,
    parameter int unsigned DWELL_01 = DWELL_01_CYC,
    parameter int unsigned DWELL_10 = DWELL_10_CYC,
    parameter int unsigned DWELL_11 = DWELL_11_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // register port from the serial interface logic
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // sink and analog controls
    output logic primary_sink_on_o,
    output logic secondary_sink_on_o,
    output logic secondary_feedback_o,
    output logic analog_en_o,
    // sink current levels, thousandths of a percent of full scale
    output logic [16:0] primary_level_o,
    output logic [16:0] secondary_level_o
);

    //------------------------------------------------------------------
    // reset release
    //------------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;

    // asynchronous assert, release after two edges to avoid a ragged start
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    logic [5:0] gp_r;
    logic [5:0] gp_nxt;
    logic [4:0] pri_code_r;
    logic [4:0] pri_code_nxt;
    logic [4:0] sec_code_r;
    logic [4:0] sec_code_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    // writes store only the bits that steer logic; reads are registered
    always_comb begin
        gp_nxt = gp_r;
        pri_code_nxt = pri_code_r;
        sec_code_nxt = sec_code_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = reg_rd_i;
        if (reg_wr_i) begin
            if (reg_addr_i == GP_ADDR) begin
                gp_nxt = reg_wdata_i[5:0];
            end else if (reg_addr_i == PRI_BRIGHT_ADDR) begin
                pri_code_nxt = reg_wdata_i[4:0];
            end else if (reg_addr_i == SEC_BRIGHT_ADDR) begin
                sec_code_nxt = reg_wdata_i[4:0];
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == GP_ADDR) begin
                rdata_nxt = {GP_FILL_ONES, gp_r};
            end else if (reg_addr_i == PRI_BRIGHT_ADDR) begin
                rdata_nxt = {BRIGHT_FILL_ONES, pri_code_r};
            end else if (reg_addr_i == SEC_BRIGHT_ADDR) begin
                rdata_nxt = {BRIGHT_FILL_ONES, sec_code_r};
            end else begin
                rdata_nxt = UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gp_r <= GP_RESET[5:0];
            pri_code_r <= BRIGHT_RESET[4:0];
            sec_code_r <= BRIGHT_RESET[4:0];
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            gp_r <= gp_nxt;
            pri_code_r <= pri_code_nxt;
            sec_code_r <= sec_code_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;

    //------------------------------------------------------------------
    // mode decode
    //------------------------------------------------------------------
    logic pri_enable;
    logic sec_enable;
    logic unison;
    logic fb_mode;
    dsbr_rate_t rate_sel;
    logic [22:0] dwell;
    logic [1:0] chan_en;
    logic [4:0] chan_code [2];
    logic [4:0] chan_app [2];
    logic [16:0] chan_level [2];

    assign pri_enable = gp_r[GP_PRI_EN_BIT];
    assign sec_enable = gp_r[GP_SEC_EN_BIT];
    assign unison = gp_r[GP_UNI_BIT];
    assign fb_mode = gp_r[GP_FB_BIT];
    assign rate_sel = dsbr_rate_t'({gp_r[GP_RATE_LO_BIT], gp_r[GP_RATE_HI_BIT]});

    // per sink enable and code source; feedback mode wins over unison
    always_comb begin
        chan_en[0] = pri_enable;
        chan_code[0] = pri_code_r;
        if (fb_mode) begin
            chan_en[1] = 1'b0;
            chan_code[1] = sec_code_r;
        end else if (unison) begin
            chan_en[1] = pri_enable;
            chan_code[1] = pri_code_r;
        end else begin
            chan_en[1] = sec_enable;
            chan_code[1] = sec_code_r;
        end
    end

    // rate pair picks the divider length; read live so a change hits the next step
    always_comb begin
        case (rate_sel)
            DSBR_RATE_51US: dwell = DWELL_W'(DWELL_00);
            DSBR_RATE_13MS: dwell = DWELL_W'(DWELL_01);
            DSBR_RATE_26MS: dwell = DWELL_W'(DWELL_10);
            default: dwell = DWELL_W'(DWELL_11);
        endcase
    end

    //------------------------------------------------------------------
    // ramp channels
    //------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_chan
        dsbr_ramp u_ramp (
            .core_clk_i(core_clk_i),
            .rst_n_i(rst_n),
            .en_i(chan_en[i]),
            .clear_i((i == 1) && fb_mode),
            .code_i(chan_code[i]),
            .dwell_i(dwell),
            .applied_o(chan_app[i])
        );
        dsbr_level_rom u_rom (
            .core_clk_i(core_clk_i),
            .rst_n_i(rst_n),
            .code_i(chan_app[i]),
            .level_o(chan_level[i])
        );
    end

    assign primary_level_o = chan_level[0];
    assign secondary_level_o = chan_level[1];

    //------------------------------------------------------------------
    // sink and analog controls
    //------------------------------------------------------------------
    logic pri_on_r;
    logic pri_on_nxt;
    logic sec_on_r;
    logic sec_on_nxt;
    logic fb_r;
    logic analog_r;
    logic analog_nxt;

    // a sink stays on while fading so a dropped enable can ramp to zero
    always_comb begin
        pri_on_nxt = chan_en[0] || (chan_app[0] != CODE_ZERO);
        sec_on_nxt = !fb_mode && (chan_en[1] || (chan_app[1] != CODE_ZERO));
        analog_nxt = pri_enable || sec_enable || fb_mode || pri_on_r || sec_on_r;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pri_on_r <= 1'b0;
            sec_on_r <= 1'b0;
            fb_r <= 1'b0;
            analog_r <= 1'b0;
        end else begin
            pri_on_r <= pri_on_nxt;
            sec_on_r <= sec_on_nxt;
            fb_r <= fb_mode;
            analog_r <= analog_nxt;
        end
    end

    assign primary_sink_on_o = pri_on_r;
    assign secondary_sink_on_o = sec_on_r;
    assign secondary_feedback_o = fb_r;
    assign analog_en_o = analog_r;

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n);

    property p_uni_on;
        unison && !fb_mode && pri_enable |=> primary_sink_on_o && secondary_sink_on_o;
    endproperty
    a_uni_on: assert property (p_uni_on)
        else $error("unison enable did not turn both sinks on");

    property p_uni_off;
        unison && !fb_mode && !pri_enable |-> !chan_en[1] && !chan_en[0];
    endproperty
    a_uni_off: assert property (p_uni_off)
        else $error("unison sinks not disabled");

    property p_sec_only;
        !unison && !fb_mode && !pri_enable && sec_enable
            |-> !chan_en[0] && chan_en[1] && chan_code[1] == sec_code_r;
    endproperty
    a_sec_only: assert property (p_sec_only)
        else $error("secondary only mode decoded wrong");

    property p_pri_only;
        !unison && !fb_mode && pri_enable && !sec_enable
            |-> chan_en[0] && !chan_en[1] && chan_code[0] == pri_code_r;
    endproperty
    a_pri_only: assert property (p_pri_only)
        else $error("primary only mode decoded wrong");

    property p_indep;
        !unison && !fb_mode && pri_enable && sec_enable |->
            chan_en == 2'h3 && chan_code[1] == sec_code_r && chan_code[0] == pri_code_r;
    endproperty
    a_indep: assert property (p_indep)
        else $error("independent levels not routed");

    property p_fb_off;
        fb_mode |=> !secondary_sink_on_o && chan_app[1] == CODE_ZERO ##1
            secondary_level_o == 17'h00000;
    endproperty
    a_fb_off: assert property (p_fb_off)
        else $error("secondary sink active in feedback mode");

    property p_analog;
        (pri_enable || sec_enable || fb_mode) |=> analog_en_o;
    endproperty
    a_analog: assert property (p_analog)
        else $error("analog enable missing");

    property p_read_ones;
        reg_rd_i && (reg_addr_i == PRI_BRIGHT_ADDR || reg_addr_i == SEC_BRIGHT_ADDR)
            |=> reg_rvalid_o && reg_rdata_o[7:5] == BRIGHT_FILL_ONES;
    endproperty
    a_read_ones: assert property (p_read_ones)
        else $error("brightness read upper bits not ones");

    property p_low_bits;
        reg_wr_i && reg_addr_i == PRI_BRIGHT_ADDR |=> pri_code_r == $past(reg_wdata_i[4:0]);
    endproperty
    a_low_bits: assert property (p_low_bits)
        else $error("brightness code not taken from low bits");

    property p_slow_rate;
        rate_sel == DSBR_RATE_52MS |-> dwell == DWELL_W'(DWELL_11);
    endproperty
    a_slow_rate: assert property (p_slow_rate)
        else $error("slowest rate not selected");

    // enabling from dark takes the lowest code first instead of jumping
    property p_soft_start;
        $rose(pri_enable) && chan_app[0] == CODE_ZERO && pri_code_r != CODE_ZERO
            |=> chan_app[0] == 5'h01;
    endproperty
    a_soft_start: assert property (p_soft_start)
        else $error("enabled sink skipped the ramp");

    // nothing enabled and nothing fading leaves the analog side off
    property p_quiet;
        !pri_enable && !sec_enable && !fb_mode && !primary_sink_on_o && !secondary_sink_on_o
            |=> !analog_en_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("analog enable stayed on with everything off");

    c_uni: cover property (unison && pri_enable && secondary_sink_on_o);
    c_fb: cover property (fb_mode && primary_sink_on_o);
    c_fade: cover property (!pri_enable && primary_sink_on_o);

endmodule

/* logic/dsbr_pkg.sv */
// constants shared by the dual sink brightness ramp block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package dsbr_pkg;

    //------------------------------------------------------------------
    // register map
    //------------------------------------------------------------------
    localparam logic [7:0] GP_ADDR = 8'h10;
    localparam logic [7:0] PRI_BRIGHT_ADDR = 8'ha0;
    localparam logic [7:0] SEC_BRIGHT_ADDR = 8'hb0;
    localparam logic [7:0] GP_RESET = 8'hc0;
    localparam logic [7:0] BRIGHT_RESET = 8'he0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // general purpose register fields
    localparam int GP_PRI_EN_BIT = 0;
    localparam int GP_SEC_EN_BIT = 1;
    localparam int GP_UNI_BIT = 2;
    localparam int GP_RATE_LO_BIT = 3;
    localparam int GP_RATE_HI_BIT = 4;
    localparam int GP_FB_BIT = 5;
    localparam logic [1:0] GP_FILL_ONES = 2'h3;

    // brightness fields
    localparam int CODE_W = 5;
    localparam logic [2:0] BRIGHT_FILL_ONES = 3'h7;
    localparam logic [4:0] CODE_MAX = 5'h1f;
    localparam logic [4:0] CODE_ZERO = 5'h00;

    // level in thousandths of a percent of full scale
    localparam int LEVEL_W = 17;
    localparam logic [16:0] FULL_SCALE_LEVEL = 17'h186a0;

    //------------------------------------------------------------------
    // step interval timing
    //------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STEP_RATE_00_NS = 51000;
    localparam int unsigned STEP_RATE_01_NS = 13000000;
    localparam int unsigned STEP_RATE_10_NS = 26000000;
    localparam int unsigned STEP_RATE_11_NS = 52000000;
    localparam int unsigned DWELL_00_CYC = (STEP_RATE_00_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DWELL_01_CYC = (STEP_RATE_01_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DWELL_10_CYC = (STEP_RATE_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DWELL_11_CYC = (STEP_RATE_11_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DWELL_W = 23;

    // ramp rate selection, written as {rate_bit_lo, rate_bit_hi}
    typedef enum logic [1:0] {
        DSBR_RATE_51US = 2'h0,
        DSBR_RATE_13MS = 2'h1,
        DSBR_RATE_26MS = 2'h2,
        DSBR_RATE_52MS = 2'h3
    } dsbr_rate_t;

endpackage

/* logic/dsbr_level_rom.sv */
// exponential code to current level table with registered output
`timescale 1ns/1ps
module dsbr_level_rom
    import dsbr_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // lookup
    input wire logic [4:0] code_i,
    output logic [16:0] level_o
);

    logic [16:0] level_r;
    logic [16:0] level_nxt;

    // table in thousandths of a percent of full scale
    always_comb begin
        case (code_i)
            5'h00: level_nxt = 17'h00000;
            5'h01: level_nxt = 17'h0007d;
            5'h02: level_nxt = 17'h00271;
            5'h03: level_nxt = 17'h003e8;
            5'h04: level_nxt = 17'h00465;
            5'h05: level_nxt = 17'h00521;
            5'h06: level_nxt = 17'h00698;
            5'h07: level_nxt = 17'h0080f;
            5'h08: level_nxt = 17'h00986;
            5'h09: level_nxt = 17'h00afd;
            5'h0a: level_nxt = 17'h00c35;
            5'h0b: level_nxt = 17'h00ea6;
            5'h0c: level_nxt = 17'h01117;
            5'h0d: level_nxt = 17'h01482;
            5'h0e: level_nxt = 17'h0186a;
            5'h0f: level_nxt = 17'h01d4c;
            5'h10: level_nxt = 17'h0222e;
            5'h11: level_nxt = 17'h02710;
            5'h12: level_nxt = 17'h030d4;
            5'h13: level_nxt = 17'h03a98;
            5'h14: level_nxt = 17'h041eb;
            5'h15: level_nxt = 17'h0493e;
            5'h16: level_nxt = 17'h057e4;
            5'h17: level_nxt = 17'h0668a;
            5'h18: level_nxt = 17'h07a12;
            5'h19: level_nxt = 17'h0927c;
            5'h1a: level_nxt = 17'h0aae6;
            5'h1b: level_nxt = 17'h0cd14;
            5'h1c: level_nxt = 17'h0ef42;
            5'h1d: level_nxt = 17'h11170;
            5'h1e: level_nxt = 17'h155cc;
            default: level_nxt = FULL_SCALE_LEVEL;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_r <= 17'h00000;
        end else begin
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;

    // end points of the table
    property p_table_ends;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (code_i == CODE_ZERO || code_i == CODE_MAX) |=>
            level_o == (($past(code_i) == CODE_MAX) ? FULL_SCALE_LEVEL : 17'h00000);
    endproperty
    a_table_ends: assert property (p_table_ends)
        else $error("level table end point wrong");

endmodule

/* logic/dsbr_ramp.sv */
// one sink: steps the applied code toward its target, one code per dwell
`timescale 1ns/1ps
module dsbr_ramp
    import dsbr_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic en_i,
    input wire logic clear_i,
    input wire logic [4:0] code_i,
    input wire logic [22:0] dwell_i,
    // state
    output logic [4:0] applied_o
);

    logic [4:0] app_r;
    logic [4:0] app_nxt;
    logic [4:0] tgt_r;
    logic [4:0] tgt_nxt;
    logic [22:0] cnt_r;
    logic [22:0] cnt_nxt;
    logic [4:0] eff;
    logic rising;

    // target tracking, stepping and the dwell divider
    always_comb begin
        app_nxt = app_r;
        tgt_nxt = tgt_r;
        cnt_nxt = cnt_r;
        eff = en_i ? code_i : CODE_ZERO;
        rising = tgt_r > app_r;
        if (clear_i) begin
            app_nxt = CODE_ZERO;
            tgt_nxt = CODE_ZERO;
            cnt_nxt = 23'h000000;
        end else if (app_r == tgt_r) begin
            // idle: accept the new target and take the first step at once
            tgt_nxt = eff;
            cnt_nxt = 23'h000000;
            if (eff != app_r) begin
                app_nxt = (eff > app_r) ? app_r + 5'h01 : app_r - 5'h01;
                if (app_nxt != eff) begin
                    cnt_nxt = dwell_i - 23'h000001;
                end
            end
        end else begin
            if (!en_i) begin
                tgt_nxt = CODE_ZERO;
            end else if ((rising && eff > tgt_r) || (!rising && eff < tgt_r)) begin
                // same direction: extend; opposite side waits for this ramp to end
                tgt_nxt = eff;
            end
            if (cnt_r == 23'h000000) begin
                app_nxt = (tgt_nxt > app_r) ? app_r + 5'h01 : app_r - 5'h01;
                cnt_nxt = (app_nxt != tgt_nxt) ? dwell_i - 23'h000001 : 23'h000000;
            end else if (cnt_r > dwell_i - 23'h000001) begin
                cnt_nxt = dwell_i - 23'h000001;
            end else begin
                cnt_nxt = cnt_r - 23'h000001;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            app_r <= CODE_ZERO;
            tgt_r <= CODE_ZERO;
            cnt_r <= 23'h000000;
        end else begin
            app_r <= app_nxt;
            tgt_r <= tgt_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign applied_o = app_r;

    // except when clear_i forces zero, the applied code never jumps more than one code
    property p_single_step;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !clear_i |=> (app_r == $past(app_r)) || (app_r == $past(app_r) + 5'h01)
            || (app_r == $past(app_r) - 5'h01);
    endproperty
    a_single_step: assert property (p_single_step)
        else $error("applied code moved by more than one");

    // idle with a differing request steps on the next edge
    property p_first_step;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!clear_i && app_r == tgt_r && eff != app_r) |=> app_r != $past(app_r);
    endproperty
    a_first_step: assert property (p_first_step)
        else $error("first step was delayed");

    // after an intermediate step the code holds while the divider runs
    property p_dwell_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!clear_i && app_nxt != app_r && app_nxt != tgt_nxt && dwell_i > 23'h000001)
            ##1 !clear_i |=> app_r == $past(app_r);
    endproperty
    a_dwell_hold: assert property (p_dwell_hold)
        else $error("code stepped before the dwell ended");

    // a dropped enable never lets the code rise
    property p_drop_falls;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!en_i && !clear_i && app_r != tgt_r) |=> app_r <= $past(app_r);
    endproperty
    a_drop_falls: assert property (p_drop_falls)
        else $error("code rose after enable was cleared");

    c_ramp_done: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        app_r == CODE_MAX);

endmodule

/* sim/dsbr_host_model.sv */
// host model that drives the register strobe port of the brightness block
`timescale 1ns/1ps
module dsbr_host_model (
    // clock
    input wire logic core_clk_i,
    // register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    // idle port at time zero
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // one access; released lines show the inverse so stale values cannot pass
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge core_clk_i);
        #1;
        reg_wr_o = w;
        reg_rd_o = !w;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge core_clk_i);
        #1;
        q = reg_rvalid_i ? reg_rdata_i : 8'hxx;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench for the dual sink brightness block
`timescale 1ns/1ps
module tb_top;
    import dsbr_pkg::*;
    localparam int unsigned LVL [32] = '{0, 125, 625, 1000, 1125, 1313, 1688, 2063, 2438,
        2813, 3125, 3750, 4375, 5250, 6250, 7500, 8750, 10000, 12500, 15000, 16875, 18750,
        22500, 26250, 31250, 37500, 43750, 52500, 61250, 70000, 87500, 100000};
    localparam int unsigned DW [4] = '{4, 6, 8, 10};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr, rd, rvalid, p_on, s_on, fb_o, an_en, so;
    logic [7:0] addr, wdata, rdata, q, a, b, g;
    logic [16:0] plv, slv, mx;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    logic [31:0] seed = 32'h0000330f;

    // short dwells keep every ramp within a few hundred cycles
    dsbr_top #(.DWELL_00(4), .DWELL_01(6), .DWELL_10(8), .DWELL_11(10)) dsbr_top_i (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .primary_sink_on_o(p_on), .secondary_sink_on_o(s_on), .secondary_feedback_o(fb_o),
        .analog_en_o(an_en), .primary_level_o(plv), .secondary_level_o(slv));
    dsbr_host_model host_i (.core_clk_i(core_clk), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    // clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            test_done();
        end
    end

    function automatic logic [16:0] lv(input logic [4:0] c);
        return 17'(LVL[c]);
    endfunction
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            n_mismatch++;
        end
    endtask
    task automatic wrr(input logic [7:0] ad, input logic [7:0] d);
        host_i.xfer(1'b1, ad, d, q);
    endtask
    task automatic rdc(input string nm, input logic [7:0] ad, input logic [7:0] exp);
        host_i.xfer(1'b0, ad, 8'h00, q);
        chk(nm, 17'(q), 17'(exp));
    endtask
    // cycles until the primary level reaches a value, bounded
    task automatic meas(input logic [16:0] t);
        n = 0;
        while (plv !== t && n < 2000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask
    // highest primary level over a window
    task automatic track(input int c);
        mx = 17'h0;
        repeat (c) begin
            @(posedge core_clk);
            #1;
            if (plv > mx) mx = plv;
        end
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        rdc("gp_rst", GP_ADDR, 8'hc0);
        rdc("pri_rst", PRI_BRIGHT_ADDR, 8'he0);
        rdc("sec_rst", SEC_BRIGHT_ADDR, 8'he0);
        wrr(8'h80, 8'h5a);
        rdc("unmapped", 8'h80, 8'h00);
        // every row of the mode table with random codes and upper bits
        for (int m = 0; m < 16; m++) begin
            a = rnd();
            b = rnd();
            g = {2'b00, m[3], 2'b00, m[2], m[1], m[0]};
            wrr(PRI_BRIGHT_ADDR, a);
            wrr(SEC_BRIGHT_ADDR, b);
            wrr(GP_ADDR, g);
            rdc("pri_rd", PRI_BRIGHT_ADDR, {3'h7, a[4:0]});
            rdc("sec_rd", SEC_BRIGHT_ADDR, {3'h7, b[4:0]});
            repeat (400) @(posedge core_clk);
            so = !m[3] && (m[2] ? m[0] : m[1]);
            chk("pri_on", p_on, m[0]);
            chk("sec_on", s_on, so);
            chk("fb", fb_o, m[3]);
            chk("analog", an_en, m[0] | m[1] | m[3]);
            chk("pri_lvl", plv, m[0] ? lv(a[4:0]) : 17'h0);
            chk("sec_lvl", slv, so ? lv(m[2] ? a[4:0] : b[4:0]) : 17'h0);
        end
        wrr(GP_ADDR, 8'h00);
        wrr(PRI_BRIGHT_ADDR, 8'h1f);
        repeat (400) @(posedge core_clk);
        // full-scale ramps up and down at each rate
        for (int r = 0; r < 4; r++) begin
            g = {3'h0, r[0], r[1], 3'h1};
            wrr(GP_ADDR, g);
            meas(lv(5'h1f));
            chk("ramp_up", 17'(n), 17'(2 + 30 * DW[r]));
            wrr(GP_ADDR, g & 8'hfe);
            meas(17'h0);
            chk("ramp_dn", 17'(n), 17'(2 + 30 * DW[r]));
        end
        // rate dropped to the fastest mid-rise: the remaining steps use the new dwell
        wrr(GP_ADDR, 8'h19);
        repeat (20) @(posedge core_clk);
        wrr(GP_ADDR, 8'h01);
        meas(lv(5'h1f));
        chk("rate_chg", 17'(n > 28 * DW[0] && n < 28 * DW[0] + DW[3]), 17'h1);
        wrr(GP_ADDR, 8'h00);
        meas(17'h0);
        // enable dropped mid-rise fades without reaching the target
        wrr(GP_ADDR, 8'h01);
        repeat (22) @(posedge core_clk);
        wrr(GP_ADDR, 8'h00);
        track(300);
        chk("fade_max", 17'(mx == lv(5'h1f)), 17'h0);
        chk("fade_end", plv, 17'h0);
        // opposite rewrite mid-rise still reaches the earlier target first
        wrr(PRI_BRIGHT_ADDR, 8'h01);
        wrr(GP_ADDR, 8'h01);
        repeat (20) @(posedge core_clk);
        wrr(PRI_BRIGHT_ADDR, 8'h1f);
        repeat (40) @(posedge core_clk);
        wrr(PRI_BRIGHT_ADDR, 8'h09);
        track(400);
        chk("rev_max", mx, lv(5'h1f));
        chk("rev_end", plv, lv(5'h09));
        test_done();
    end
endmodule
